// ---- isx_cfg.svh ----
// constants for the inertial sensor serial link, both ends
`ifndef ISX_CFG_SVH
`define ISX_CFG_SVH

`define ISX_MCLK_HZ      10000000
`define ISX_FRAME_BITS   32
`define ISX_CNT_W        6
`define ISX_PAY_BITS     28
`define ISX_CRC_BITS     4
`define ISX_CRC_INIT     4'hA
`define ISX_CRC_POLY     4'h1
`define ISX_ERR_WORD     32'h00000903
`define ISX_SCLK_MAX_HZ  8000000
`define ISX_HALF_CYC     4'h8
`define ISX_RATE_SPS     8000
`define ISX_RATE_DIV     (`ISX_MCLK_HZ / `ISX_RATE_SPS)
`define ISX_RATE_W       11
`define ISX_HWRST_MS     10
`define ISX_BOOT_MS      250
`define ISX_WAIT_W       22

`endif

// ---- isx_pkg.sv ----
// state types for each end of the link and the frame check that both ends share
`include "isx_cfg.svh"
package isx_pkg;

    typedef enum logic [7:0] {
        ISX_H_RESET = 8'h01,
        ISX_H_BOOT  = 8'h02,
        ISX_H_IDLE  = 8'h04,
        ISX_H_LEAD  = 8'h08,
        ISX_H_HIGH  = 8'h10,
        ISX_H_LOW   = 8'h20,
        ISX_H_TRAIL = 8'h40,
        ISX_H_GAP   = 8'h80
    } isx_hstate_t;

    typedef struct packed {
        logic                   cs_s1;
        logic                   cs_s2;
        logic                   cs_d;
        logic                   sclk_s1;
        logic                   sclk_s2;
        logic                   sclk_d;
        logic                   mosi_s1;
        logic                   mosi_s2;
        logic                   hr_s1;
        logic                   hr_s2;
        logic [31:0]            rx;
        logic [31:0]            tx;
        logic [`ISX_CNT_W-1:0]  cnt;
        logic                   oe;
        logic                   err;
        logic                   cnt_err;
        logic                   crc_err;
        logic                   ovr_err;
        logic                   out_v;
        logic [27:0]            out_d;
        logic                   sp_v;
        logic [27:0]            sp_d;
        logic [`ISX_RATE_W-1:0] div;
        logic                   tick;
    } isx_dstate_t;

    typedef struct packed {
        isx_hstate_t            st;
        logic [`ISX_WAIT_W-1:0] wait_cnt;
        logic [3:0]             div;
        logic [`ISX_CNT_W-1:0]  bits;
        logic [31:0]            tx;
        logic [31:0]            rx;
        logic                   cs_n;
        logic                   sclk;
        logic                   mosi;
        logic                   hr_n;
        logic                   miso_s1;
        logic                   miso_s2;
        logic                   rdy;
        logic                   rv;
        logic [31:0]            rword;
        logic                   rok;
    } isx_hst_t;

    // runs over the 28 payload bits, most significant first
    function automatic logic [3:0] isx_crc(input logic [27:0] d);
        logic [3:0] c;
        logic       fb;
        c  = `ISX_CRC_INIT;
        fb = 1'b0;
        for (int i = 27; i >= 0; i--) begin
            fb = c[3] ^ d[i];
            c  = {c[2:0], 1'b0} ^ (fb ? `ISX_CRC_POLY : 4'h0);
        end
        return c;
    endfunction

endpackage

// ---- isx_if.sv ----
// serial link wires between host and sensor
`timescale 1ns/10ps
interface isx_if;
    logic chip_select_low;
    logic sclk;
    logic mosi;
    logic miso_out;
    logic miso_oe;
    logic hardware_reset_low;
    logic miso;

    // released line reads high, as through a pull-up
    assign miso = miso_oe ? miso_out : 1'b1;

    modport dev (
        input  chip_select_low,
        input  sclk,
        input  mosi,
        input  hardware_reset_low,
        output miso_out,
        output miso_oe
    );

    modport host (
        output chip_select_low,
        output sclk,
        output mosi,
        output hardware_reset_low,
        input  miso
    );
endinterface

// ---- isx_dev.sv ----
// sensor end of the link: slave shifter, frame check, command buffer
`timescale 1ns/10ps
`include "isx_cfg.svh"
module isx_dev (
    input  wire logic        mclk_i,        // system clock
    input  wire logic        rst_i,         // synchronous reset, high
    isx_if.dev               lnk,           // serial link
    output logic [27:0]      cmd_data_o,    // accepted command payload
    output logic             cmd_valid_o,   // command waiting
    input  wire logic        cmd_ready_i,   // consumer takes command
    input  wire logic [27:0] resp_i,        // payload for next response
    output logic             sample_tick_o, // internal sample strobe
    output logic             spi_err_o,     // last frame failed
    output logic             cnt_err_o,     // last frame clock count wrong
    output logic             crc_err_o,     // last frame check failed
    output logic             ovr_err_o      // last frame lost, buffer full
);

    localparam isx_pkg::isx_dstate_t RST_VAL = '{
        cs_s1:   1'b1,
        cs_s2:   1'b1,
        cs_d:    1'b1,
        sclk_s1: 1'b0,
        sclk_s2: 1'b0,
        sclk_d:  1'b0,
        mosi_s1: 1'b0,
        mosi_s2: 1'b0,
        hr_s1:   1'b0,
        hr_s2:   1'b0,
        rx:      32'h00000000,
        tx:      32'h00000000,
        cnt:     6'h00,
        oe:      1'b0,
        err:     1'b0,
        cnt_err: 1'b0,
        crc_err: 1'b0,
        ovr_err: 1'b0,
        out_v:   1'b0,
        out_d:   28'h0000000,
        sp_v:    1'b0,
        sp_d:    28'h0000000,
        div:     11'h000,
        tick:    1'b0
    };

    localparam logic [`ISX_RATE_W-1:0] RATE_LAST =
        `ISX_RATE_W'(`ISX_RATE_DIV - 1);
    localparam logic [`ISX_CNT_W-1:0] FRAME_CNT =
        `ISX_CNT_W'(`ISX_FRAME_BITS);
    localparam logic [`ISX_CNT_W-1:0] CNT_MAX = 6'h3F;

    // pins are seen three cycles late: with the host's own two-flop
    // sample on miso, sclk halves under six cycles would lose bits;
    // a faster link needs the pins sampled on a faster clock

    isx_pkg::isx_dstate_t s_reg;
    isx_pkg::isx_dstate_t s_next;

    // per-cycle helpers, all set by the process below
    logic        cs_fall;
    logic        cs_rise;
    logic        sc_rise;
    logic        sc_fall;
    logic        good;
    logic        cnt_ok;
    logic        crc_ok;
    logic        room;
    logic [27:0] word;
    logic [5:0]  cnt_base;

    always_comb begin
        s_next = s_reg;
        // first stages feed only the second stages
        s_next.cs_s1   = lnk.chip_select_low;
        s_next.cs_s2   = s_reg.cs_s1;
        s_next.sclk_s1 = lnk.sclk;
        s_next.sclk_s2 = s_reg.sclk_s1;
        s_next.mosi_s1 = lnk.mosi;
        s_next.mosi_s2 = s_reg.mosi_s1;
        s_next.hr_s1   = lnk.hardware_reset_low;
        s_next.hr_s2   = s_reg.hr_s1;
        s_next.cs_d    = s_reg.cs_s2;
        s_next.sclk_d  = s_reg.sclk_s2;
        s_next.tick    = 1'b0;

        // sclk is only ever observed, never driven from here
        cs_fall = s_reg.cs_d & ~s_reg.cs_s2;
        cs_rise = ~s_reg.cs_d & s_reg.cs_s2;
        sc_rise = ~s_reg.sclk_d & s_reg.sclk_s2 & ~s_reg.cs_s2;
        sc_fall = s_reg.sclk_d & ~s_reg.sclk_s2 & ~s_reg.cs_s2;

        word   = s_reg.rx[31:4];
        cnt_ok = (s_reg.cnt == FRAME_CNT);
        crc_ok = (isx_pkg::isx_crc(word) == s_reg.rx[3:0]);
        good   = cnt_ok & crc_ok;
        room   = 1'b1;

        // an sclk rise landing with the select fall counts from zero,
        // not on top of the previous frame's total
        cnt_base = cs_fall ? 6'h00 : s_reg.cnt;

        // drain side of the two-entry buffer
        // the spare moves up first, so commands keep their order
        if (s_reg.out_v && cmd_ready_i) begin
            if (s_reg.sp_v) begin
                s_next.out_d = s_reg.sp_d;
                s_next.sp_v  = 1'b0;
            end else begin
                s_next.out_v = 1'b0;
            end
        end

        // prepared word goes into the shifter before the first rise
        if (cs_fall) begin
            s_next.oe  = 1'b1;
            s_next.cnt = 6'h00;
            // the error word replaces the answer, whatever was asked
            if (s_reg.err) begin
                s_next.tx = `ISX_ERR_WORD;
            end else begin
                s_next.tx = {resp_i, isx_pkg::isx_crc(resp_i)};
            end
        end

        if (sc_rise) begin
            s_next.rx = {s_reg.rx[30:0], s_reg.mosi_s2};
            // saturates, so a runaway clock still reads as a wrong count
            if (cnt_base != CNT_MAX) begin
                s_next.cnt = cnt_base + 6'h01;
            end
        end

        // a clash with the select fall keeps the newly loaded first bit
        if (sc_fall && !cs_fall) begin
            s_next.tx = {s_reg.tx[30:0], 1'b0};
        end

        // all frame results settle at the end of the frame
        if (cs_rise) begin
            s_next.oe = 1'b0;
            room = ~(s_next.out_v & s_next.sp_v);
            // a full buffer drops the word rather than stall the link;
            // the host learns of it from the error word next frame
            if (good && room) begin
                if (!s_next.out_v) begin
                    s_next.out_v = 1'b1;
                    s_next.out_d = word;
                end else begin
                    s_next.sp_v = 1'b1;
                    s_next.sp_d = word;
                end
            end
            // a failed frame never reaches the consumer
            s_next.err     = ~(good & room);
            s_next.cnt_err = ~cnt_ok;
            s_next.crc_err = cnt_ok & ~crc_ok;
            s_next.ovr_err = good & ~room;
        end

        // sample strobe runs off the system clock, not sclk; a held hardware reset restarts it
        if (s_reg.div == RATE_LAST) begin
            s_next.div  = 11'h000;
            s_next.tick = 1'b1;
        end else begin
            s_next.div = s_reg.div + 11'h001;
        end

        // held hardware reset clears all but the synchronisers, which
        // keep running so the release is seen on its own edge; a reset
        // inside a frame leaves a short count, reported next frame
        if (!s_reg.hr_s2) begin
            s_next         = RST_VAL;
            s_next.cs_s1   = lnk.chip_select_low;
            s_next.cs_s2   = s_reg.cs_s1;
            s_next.cs_d    = s_reg.cs_s2;
            s_next.sclk_s1 = lnk.sclk;
            s_next.sclk_s2 = s_reg.sclk_s1;
            s_next.sclk_d  = s_reg.sclk_s2;
            s_next.mosi_s1 = lnk.mosi;
            s_next.mosi_s2 = s_reg.mosi_s1;
            s_next.hr_s1   = lnk.hardware_reset_low;
            s_next.hr_s2   = s_reg.hr_s1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_reg <= RST_VAL;
        end else begin
            s_reg <= s_next;
        end
    end

    // answer of one frame is shifted out in the next one
    assign lnk.miso_out  = s_reg.tx[31];
    assign lnk.miso_oe   = s_reg.oe;

    // consumer side; the flags describe the latest frame only
    assign cmd_data_o    = s_reg.out_d;
    assign cmd_valid_o   = s_reg.out_v;
    assign sample_tick_o = s_reg.tick;
    assign spi_err_o     = s_reg.err;
    assign cnt_err_o     = s_reg.cnt_err;
    assign crc_err_o     = s_reg.crc_err;
    assign ovr_err_o     = s_reg.ovr_err;

endmodule

// ---- isx_host.sv ----
// host end of the link: reset, start-up wait and frame master
`timescale 1ns/10ps
`include "isx_cfg.svh"
module isx_host #(
    parameter int unsigned HWRST_CYCLES =
        `ISX_HWRST_MS * (`ISX_MCLK_HZ / 1000),
    parameter int unsigned BOOT_CYCLES =
        `ISX_BOOT_MS * (`ISX_MCLK_HZ / 1000)
) (
    input  wire logic        mclk_i,        // system clock
    input  wire logic        rst_i,         // synchronous reset, high
    isx_if.host              lnk,           // serial link
    input  wire logic        req_valid_i,   // command offered
    input  wire logic [27:0] req_word_i,    // command payload
    output logic             req_ready_o,   // command can be taken
    output logic             resp_valid_o,  // received word waiting
    output logic [31:0]      resp_word_o,   // received frame
    output logic             resp_crc_ok_o, // received check matches
    input  wire logic        resp_ready_i   // consumer takes word
);

    localparam logic [`ISX_WAIT_W-1:0] HWRST_LAST =
        `ISX_WAIT_W'(HWRST_CYCLES - 1);
    localparam logic [`ISX_WAIT_W-1:0] BOOT_LAST =
        `ISX_WAIT_W'(BOOT_CYCLES - 1);
    localparam logic [3:0] HALF_LAST = `ISX_HALF_CYC - 4'h1;
    localparam logic [`ISX_CNT_W-1:0] BITS_LAST =
        `ISX_CNT_W'(`ISX_FRAME_BITS - 1);

    isx_pkg::isx_hst_t h_reg;
    isx_pkg::isx_hst_t h_next;
    logic              half_done;

    always_comb begin
        h_next         = h_reg;
        h_next.miso_s1 = lnk.miso;
        h_next.miso_s2 = h_reg.miso_s1;
        h_next.div     = h_reg.div + 4'h1;
        half_done      = (h_reg.div == HALF_LAST);
        if (h_reg.rv && resp_ready_i) begin
            h_next.rv = 1'b0;
        end
        unique case (h_reg.st)
            isx_pkg::ISX_H_RESET: begin
                h_next.hr_n     = 1'b0;
                h_next.wait_cnt = h_reg.wait_cnt + 22'h000001;
                if (h_reg.wait_cnt == HWRST_LAST) begin
                    h_next.hr_n     = 1'b1;
                    h_next.wait_cnt = 22'h000000;
                    h_next.st       = isx_pkg::ISX_H_BOOT;
                end
            end
            isx_pkg::ISX_H_BOOT: begin
                h_next.wait_cnt = h_reg.wait_cnt + 22'h000001;
                if (h_reg.wait_cnt == BOOT_LAST) begin
                    h_next.st = isx_pkg::ISX_H_IDLE;
                end
            end
            isx_pkg::ISX_H_IDLE: begin
                if (req_valid_i && h_reg.rdy) begin
                    h_next.tx   = {req_word_i,
                                   isx_pkg::isx_crc(req_word_i)};
                    h_next.mosi = req_word_i[27];
                    h_next.cs_n = 1'b0;
                    h_next.div  = 4'h0;
                    h_next.bits = 6'h00;
                    h_next.st   = isx_pkg::ISX_H_LEAD;
                end
            end
            isx_pkg::ISX_H_LEAD,
            isx_pkg::ISX_H_LOW: begin
                if (half_done) begin
                    // half period of 8 cycles keeps sclk far below 8 MHz
                    h_next.sclk = 1'b1;
                    h_next.rx   = {h_reg.rx[30:0], h_reg.miso_s2};
                    h_next.div  = 4'h0;
                    h_next.st   = isx_pkg::ISX_H_HIGH;
                end
            end
            isx_pkg::ISX_H_HIGH: begin
                if (half_done) begin
                    h_next.sclk = 1'b0;
                    h_next.div  = 4'h0;
                    h_next.bits = h_reg.bits + 6'h01;
                    if (h_reg.bits == BITS_LAST) begin
                        h_next.st = isx_pkg::ISX_H_TRAIL;
                    end else begin
                        h_next.tx   = {h_reg.tx[30:0], 1'b0};
                        h_next.mosi = h_reg.tx[30];
                        h_next.st   = isx_pkg::ISX_H_LOW;
                    end
                end
            end
            isx_pkg::ISX_H_TRAIL: begin
                if (half_done) begin
                    h_next.cs_n = 1'b1;
                    h_next.div  = 4'h0;
                    h_next.st   = isx_pkg::ISX_H_GAP;
                end
            end
            isx_pkg::ISX_H_GAP: begin
                if (half_done) begin
                    h_next.rv    = 1'b1;
                    h_next.rword = h_reg.rx;
                    h_next.rok   = (isx_pkg::isx_crc(h_reg.rx[31:4])
                                    == h_reg.rx[3:0]);
                    h_next.st    = isx_pkg::ISX_H_IDLE;
                end
            end
        endcase
        h_next.rdy = (h_next.st == isx_pkg::ISX_H_IDLE) & ~h_next.rv;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            h_reg          <= '0;
            h_reg.st       <= isx_pkg::ISX_H_RESET;
            h_reg.cs_n     <= 1'b1;
            h_reg.miso_s1  <= 1'b1;
            h_reg.miso_s2  <= 1'b1;
        end else begin
            h_reg <= h_next;
        end
    end

    assign lnk.chip_select_low    = h_reg.cs_n;
    assign lnk.sclk               = h_reg.sclk;
    assign lnk.mosi               = h_reg.mosi;
    assign lnk.hardware_reset_low = h_reg.hr_n;
    assign req_ready_o            = h_reg.rdy;
    assign resp_valid_o           = h_reg.rv;
    assign resp_word_o            = h_reg.rword;
    assign resp_crc_ok_o          = h_reg.rok;

endmodule

// ---- isx_chk.sv ----
// concurrent checks on the serial link between host and sensor
`timescale 1ns/10ps
module isx_chk #(
    parameter int unsigned HWRST_CYCLES = 20,
    parameter int unsigned BOOT_CYCLES  = 20
) (
    input  wire logic mclk_i,             // system clock
    input  wire logic rst_i,              // synchronous reset, high
    input  wire logic chip_select_low,    // select, low active
    input  wire logic sclk,               // serial clock
    input  wire logic mosi,               // host data
    input  wire logic miso_out,           // sensor data
    input  wire logic miso_oe,            // sensor drive enable
    input  wire logic hardware_reset_low, // sensor reset, low active
    input  wire logic miso                // resolved sensor line
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    logic [5:0]  rises;
    logic [31:0] hr_cnt;
    logic        hr_q;

    // hr_cnt saturates so the long start-up wait cannot wrap
    always_ff @(posedge mclk_i) begin
        hr_q <= hardware_reset_low;
        if (rst_i || $fell(chip_select_low))
            rises <= 6'h00;
        else if ($rose(sclk))
            rises <= rises + 6'h01;
        if (rst_i || hardware_reset_low != hr_q)
            hr_cnt <= 32'h0;
        else if (hr_cnt != 32'hFFFFFFFF)
            hr_cnt <= hr_cnt + 32'h1;
    end

    sequence s_idle;
        chip_select_low [*4];
    endsequence
    sequence s_drive;
        ##[2:4] miso_oe;
    endsequence

    a_sel_drive_on: assert property ($fell(chip_select_low) |-> s_drive)
        else $error("sensor did not drive after select fell");
    a_idle_release: assert property (s_idle |-> !miso_oe && miso)
        else $error("sensor drives while not selected");
    a_edge_clk_low: assert property ($changed(chip_select_low) |-> !sclk)
        else $error("serial clock high at a select edge");
    a_clk_still: assert property (chip_select_low |-> $stable(sclk))
        else $error("serial clock moves outside a frame");
    a_clk_half_min: assert property ($changed(sclk) |=> $stable(sclk) [*7])
        else $error("serial clock phase shorter than eight cycles");
    a_miso_fall_only: assert property ($rose(sclk) |-> $stable(miso_out) [*8])
        else $error("sensor data moved away from a falling edge");
    a_mosi_fall_only: assert property ($changed(mosi) |-> !sclk)
        else $error("host data moved while serial clock high");
    a_frame_bits: assert property ($rose(chip_select_low) |-> rises == 6'h20)
        else $error("frame did not carry 32 clocks");
    a_gap_min: assert property ($rose(chip_select_low) |=> chip_select_low [*4])
        else $error("select gap too short");
    a_hwrst_len: assert property ($rose(hardware_reset_low) |-> hr_cnt >= HWRST_CYCLES - 2)
        else $error("hardware reset pulse too short");
    a_boot_wait: assert property ($fell(chip_select_low) |-> hardware_reset_low && hr_cnt >= BOOT_CYCLES - 2)
        else $error("frame started inside start-up time");
endmodule

// ---- isx_tb_top.sv ----
// bench: host and sensor joined, plus a bench-driven second sensor
`timescale 1ns/10ps
`include "isx_cfg.svh"
module isx_tb_top;
    localparam logic [27:0] MASK = 28'h5A5A5A5;
    localparam logic [27:0] P2   = 28'h3C3C3C3;
    localparam logic [27:0] CA   = 28'h1F0E0D0;
    localparam logic [27:0] CB   = 28'hABCDEF1;
    localparam int          HW   = 20;
    logic        mclk_i     = 1'b0;
    logic        rst_i      = 1'b1;
    logic        req_valid  = 1'b0;
    logic [27:0] req_word   = 28'h0;
    logic        resp_ready = 1'b0;
    logic        cmd_ready  = 1'b1;
    logic [27:0] resp_now   = 28'h0ABCDEF;
    logic        req_ready, resp_valid, crc_ok, cmd_valid, cmd_valid2;
    logic        tick, spi_err, ovr_err, err2, cnt_err2, crc_err2;
    logic [31:0] resp_word, mo_sh, mi_sh, mo_fr, mi_fr;
    logic [27:0] cmd_data, cmd_data2, last2;
    logic [27:0] got [$];
    int          bits = 0;
    int          pops2 = 0;
    int          err_count = 0;
    int          samples_checked = 0;

    isx_if link_a ();
    isx_if link_b ();
    isx_host #(.HWRST_CYCLES(HW), .BOOT_CYCLES(HW)) isx_host_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .lnk(link_a),
        .req_valid_i(req_valid), .req_word_i(req_word),
        .req_ready_o(req_ready), .resp_valid_o(resp_valid),
        .resp_word_o(resp_word), .resp_crc_ok_o(crc_ok),
        .resp_ready_i(resp_ready));
    isx_dev isx_dev_i (.mclk_i(mclk_i), .rst_i(rst_i), .lnk(link_a),
        .cmd_data_o(cmd_data), .cmd_valid_o(cmd_valid),
        .cmd_ready_i(cmd_ready), .resp_i(resp_now), .sample_tick_o(tick),
        .spi_err_o(spi_err), .cnt_err_o(), .crc_err_o(),
        .ovr_err_o(ovr_err));
    // second sensor faces the bench, which breaks the framing on purpose
    isx_dev isx_dev_i2 (.mclk_i(mclk_i), .rst_i(rst_i), .lnk(link_b),
        .cmd_data_o(cmd_data2), .cmd_valid_o(cmd_valid2),
        .cmd_ready_i(1'b1), .resp_i(P2), .sample_tick_o(),
        .spi_err_o(err2), .cnt_err_o(cnt_err2), .crc_err_o(crc_err2),
        .ovr_err_o());
    isx_chk #(.HWRST_CYCLES(HW), .BOOT_CYCLES(HW)) isx_chk_i (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .chip_select_low(link_a.chip_select_low), .sclk(link_a.sclk),
        .mosi(link_a.mosi), .miso_out(link_a.miso_out),
        .miso_oe(link_a.miso_oe),
        .hardware_reset_low(link_a.hardware_reset_low),
        .miso(link_a.miso));

    always #50 mclk_i = ~mclk_i;

    // consumer answers each command with its masked payload next frame
    always @(posedge mclk_i) begin
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
            got.push_back(cmd_data);
            resp_now <= cmd_data ^ MASK;
        end
        if (cmd_valid2 === 1'b1) begin
            pops2 <= pops2 + 1;
            last2 <= cmd_data2;
        end
    end
    always @(posedge link_a.sclk) begin
        mo_sh <= {mo_sh[30:0], link_a.mosi};
        mi_sh <= {mi_sh[30:0], link_a.miso};
        bits  <= bits + 1;
    end
    always @(negedge link_a.chip_select_low) bits <= 0;
    always @(posedge link_a.chip_select_low) begin
        mo_fr <= mo_sh;
        mi_fr <= mi_sh;
    end

    function automatic logic [3:0] crc4(input logic [27:0] d);
        logic [3:0] c;
        c = 4'hA;
        for (int i = 27; i >= 0; i--)
            c = {c[2:0], 1'b0} ^ {3'h0, c[3] ^ d[i]};
        return c;
    endfunction

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic timeout(input string n);
        err_count++;
        $display("MISMATCH %s expected done seen timeout", n);
        final_report();
    endtask

    task automatic host_xfer(input logic [27:0] c, output logic [31:0] w,
                             output logic ok);
        int n;
        n = 0;
        req_word  <= c;
        req_valid <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (req_ready !== 1'b1 && n < 4000);
        if (n == 4000) timeout("host take");
        req_valid <= 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 1000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n == 1000) timeout("host answer");
        w  = resp_word;
        ok = crc_ok;
        resp_ready <= 1'b1;
        @(posedge mclk_i);
        resp_ready <= 1'b0;
    endtask

    // bit-banged frame on the second link, nb clocks of 800 ns each
    task automatic bb_frame(input logic [31:0] w, input int nb,
                            output logic [31:0] r);
        r = 32'h0;
        link_b.chip_select_low <= 1'b0;
        repeat (8) @(posedge mclk_i);
        for (int i = 0; i < nb; i++) begin
            link_b.mosi <= w[31 - (i % 32)];
            repeat (4) @(posedge mclk_i);
            link_b.sclk <= 1'b1;
            r = {r[30:0], link_b.miso};
            repeat (4) @(posedge mclk_i);
            link_b.sclk <= 1'b0;
        end
        repeat (8) @(posedge mclk_i);
        link_b.chip_select_low <= 1'b1;
        link_b.mosi <= ~link_b.mosi;
        repeat (8) @(posedge mclk_i);
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (tick !== 1'b1 && n < 2000);
        if (n == 2000) timeout("sample tick");
    endtask

    initial begin
        logic [31:0] w;
        logic        ok;
        logic [27:0] ex;
        int          n;
        int          sword;
        logic [27:0] cmds [4] = '{28'hD07A655, 28'hFFFFFFF, 28'h0000000,
                                  28'h8000001};
        int          bad_n [3] = '{31, 33, 32};
        link_b.chip_select_low = 1'b1;
        link_b.sclk = 1'b0;
        link_b.mosi = 1'b0;
        link_b.hardware_reset_low = 1'b1;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        chk("crc example", 32'hC, {28'h0, crc4(28'hD07A655)});
        ex = resp_now;
        foreach (cmds[i]) begin
            host_xfer(cmds[i], w, ok);
            chk("wire mosi", {cmds[i], crc4(cmds[i])}, mo_fr);
            chk("wire clocks", 32'h20, 32'(bits));
            chk("wire miso", {ex, crc4(ex)}, mi_fr);
            chk("answer", {ex, crc4(ex)}, w);
            chk("answer crc", 32'h1, {31'h0, ok});
            chk("command", {4'h0, cmds[i]}, {4'h0, got.pop_front()});
            sword = int'(ex[27:12]) - (ex[27] ? 65536 : 0);
            chk("signed", 32'(sword), 32'($signed(w[31:16])));
            ex = cmds[i] ^ MASK;
        end
        wait_tick(n);
        wait_tick(n);
        chk("tick spacing", `ISX_MCLK_HZ / `ISX_RATE_SPS, 32'(n));
        cmd_ready <= 1'b0;
        for (int i = 0; i < 3; i++)
            host_xfer(28'h0C0FFE0 + 28'(i), w, ok);
        chk("overflow", 32'h1, {31'h0, ovr_err});
        chk("error flag", 32'h1, {31'h0, spi_err});
        cmd_ready <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk("drained", 32'h2, 32'(got.size()));
        chk("empty", 32'h0, {31'h0, cmd_valid});
        chk("kept", {4'h0, 28'h0C0FFE0}, {4'h0, got.pop_front()});
        got.delete();
        host_xfer(28'h1234567, w, ok);
        chk("error word", `ISX_ERR_WORD, w);
        chk("flag cleared", 32'h0, {31'h0, spi_err});
        bb_frame({CA, crc4(CA)}, 32, w);
        chk("first answer", {P2, crc4(P2)}, w);
        chk("cmd taken", {4'h0, CA}, {4'h0, last2});
        chk("released", 32'h0, {31'h0, link_b.miso_oe});
        for (int k = 0; k < 3; k++) begin
            bb_frame({CA, crc4(CA) ^ {3'h0, k == 2}}, bad_n[k], w);
            chk("count flag", {31'h0, k != 2}, {31'h0, cnt_err2});
            chk("crc flag", {31'h0, k == 2}, {31'h0, crc_err2});
            chk("discarded", 32'(1 + k), 32'(pops2));
            bb_frame({CB, crc4(CB)}, 32, w);
            chk("error word b", `ISX_ERR_WORD, w);
            chk("cleared b", 32'h0, {31'h0, err2});
        end
        bb_frame(32'h0, 31, w);
        link_b.hardware_reset_low <= 1'b0;
        repeat (HW) @(posedge mclk_i);
        link_b.hardware_reset_low <= 1'b1;
        repeat (8) @(posedge mclk_i);
        chk("reset clears", 32'h0, {31'h0, err2});
        bb_frame({CA, crc4(CA)}, 32, w);
        chk("fresh answer", {P2, crc4(P2)}, w);
        final_report();
    end
endmodule
